// file: common/ciw_defines.svh
// Constants for the clock interface CSR write front end
`ifndef CIW_DEFINES_SVH
`define CIW_DEFINES_SVH
`define CIW_ADDR_W       5
`define CIW_DATA_W       32
`define CIW_PROT_W       3
`define CIW_STRB_W       4
`define CIW_RESP_W       2
`define CIW_RESP_OKAY    2'h0
`define CIW_NUM_REGS     8
`define CIW_LED_MODE_DEF 0
`define CIW_LED_MODE_MAX 2
`define CIW_REG_RST      32'h00000000
`endif

// file: common/ciw_pkg.sv
// Types for the clock interface CSR write front end
package ciw_pkg;
    // Write channel states
    typedef enum logic [1:0] {
        CIW_IDLE,
        CIW_HAVE_ADDR,
        CIW_HAVE_DATA,
        CIW_RESP
    } ciw_wstate_t;
endpackage

// file: common/ciw_reg_if.sv
// Write port between the bus front end and the register store
`timescale 1ns/1ns
`default_nettype none
`include "ciw_defines.svh"
interface ciw_reg_if;
    logic                    wrEn;   // One-cycle write strobe
    logic [2:0]              wrIdx;  // Word index
    logic [`CIW_DATA_W-1:0]  wrData; // Write data
    logic [`CIW_STRB_W-1:0]  wrStrb; // Byte enables
    modport master (output wrEn, output wrIdx, output wrData, output wrStrb);
    modport store  (input wrEn, input wrIdx, input wrData, input wrStrb);
endinterface
`default_nettype wire

// file: rtl/ciw_reg_store.sv
// Register store with byte-enabled writes
`timescale 1ns/1ns
`default_nettype none
`include "ciw_defines.svh"
module ciw_reg_store
    import ciw_pkg::*;
#(
    parameter int NUM_REGS = `CIW_NUM_REGS
) (
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    ciw_reg_if.store                      wrPort,
    output logic [NUM_REGS*`CIW_DATA_W-1:0] regFlat
);
    // ***************************************************
    // Storage
    // ***************************************************
    logic [`CIW_DATA_W-1:0] regs_ff [NUM_REGS]; // Register words

    // The write index is three bits wide; other depths cannot be addressed
    if (NUM_REGS != 8) begin : gBadDepth
        $error("NUM_REGS must be 8 for a 3-bit index");
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : gRegs
            // Selected word takes enabled bytes
            wire hit = wrPort.wrEn && (wrPort.wrIdx == 3'(g));
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    regs_ff[g] <= `CIW_REG_RST; // see [R1]
                end else if (hit) begin
                    for (int b = 0; b < `CIW_STRB_W; b++) begin
                        if (wrPort.wrStrb[b]) begin
                            regs_ff[g][b*8 +: 8] <= wrPort.wrData[b*8 +: 8]; // see [R8]
                        end
                    end
                end
            end
            assign regFlat[g*`CIW_DATA_W +: `CIW_DATA_W] = regs_ff[g];
        end
    endgenerate
endmodule
`default_nettype wire

// file: rtl/ciw_csr_write.sv
// AXI4-Lite write-side slave with LED source selection
// Functional notes
// [R1] Reset low returns control registers to initial
// [R2] Master holds 5-bit address until ready
// [R3] Write protection input ignored entirely
// [R4] Master holds valid through ready edge
// [R5] Ready when free; capture on handshake
// [R6] Build-time integer selects LED source
// [R7] Registers reached over 32-bit AXI4-Lite
// [R8] Data written on write-data handshake; the store is written when the later of the address and data handshakes lands
// [R9] OKAY response after address and data
`timescale 1ns/1ns
`default_nettype none
`include "ciw_defines.svh"
module ciw_csr_write
    import ciw_pkg::*;
#(
    parameter int INITIAL_LED_MODE = `CIW_LED_MODE_DEF
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic [`CIW_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [`CIW_PROT_W-1:0] s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [`CIW_DATA_W-1:0] s_axi_wdata,
    input  wire logic [`CIW_STRB_W-1:0] s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [`CIW_RESP_W-1:0]      s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic                   clkGood,
    input  wire logic                   vcxoValid,
    input  wire logic                   refValid,
    input  wire logic                   refLocked,
    output logic                        ledOut,
    output logic [`CIW_DATA_W-1:0]      ctrlWord
);
    // Only three LED sources exist; refuse any other mode at elaboration
    if (INITIAL_LED_MODE < 0 || INITIAL_LED_MODE > `CIW_LED_MODE_MAX) begin : gBadMode
        $error("INITIAL_LED_MODE must be 0, 1 or 2");
    end

    // ***************************************************
    // Write channel state
    // ***************************************************
    ciw_wstate_t              state_ff;    // Channel state
    ciw_wstate_t              nxt_state;   // Next state
    logic [`CIW_ADDR_W-1:0]   addr_ff;     // Captured address
    logic [`CIW_DATA_W-1:0]   data_ff;     // Captured data
    logic [`CIW_STRB_W-1:0]   strb_ff;     // Captured strobes
    logic [`CIW_DATA_W*8-1:0] regFlat;     // Store contents
    ciw_reg_if                regBus();    // Store write port

    // Protection is deliberately unused; see [R3]
    wire unusedProt = ^s_axi_awprot;

    // Handshakes; ready flags are registered outputs
    wire awHs = s_axi_awvalid && s_axi_awready; // see [R5]
    wire wHs  = s_axi_wvalid && s_axi_wready;
    wire bHs  = s_axi_bvalid && s_axi_bready;

    // Next-state decode
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CIW_IDLE: begin
                if (awHs && wHs) nxt_state = CIW_RESP;
                else if (awHs)   nxt_state = CIW_HAVE_ADDR;
                else if (wHs)    nxt_state = CIW_HAVE_DATA;
            end
            CIW_HAVE_ADDR: begin
                if (wHs) nxt_state = CIW_RESP; // see [R9]
            end
            CIW_HAVE_DATA: begin
                if (awHs) nxt_state = CIW_RESP; // see [R9]
            end
            CIW_RESP: begin
                if (bHs) nxt_state = CIW_IDLE;
            end
            default: nxt_state = CIW_IDLE;
        endcase
    end

    // Ready only in states that still need that beat
    wire nxtAwReady = (nxt_state == CIW_IDLE) || (nxt_state == CIW_HAVE_DATA);
    wire nxtWReady  = (nxt_state == CIW_IDLE) || (nxt_state == CIW_HAVE_ADDR);
    wire nxtBValid  = (nxt_state == CIW_RESP);

    // Registered channel flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff      <= CIW_IDLE; // see [R1]
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CIW_RESP_OKAY;
        end else begin
            state_ff      <= nxt_state;
            s_axi_awready <= nxtAwReady; // see [R5]
            s_axi_wready  <= nxtWReady;
            s_axi_bvalid  <= nxtBValid;  // see [R9]
            // Always OKAY: every word of the space is writable
            s_axi_bresp   <= `CIW_RESP_OKAY; // see [R9]
        end
    end

    // Address and data capture on their handshakes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= '0;
            data_ff <= '0;
            strb_ff <= '0;
        end else begin
            if (awHs) addr_ff <= s_axi_awaddr; // see [R5]
            if (wHs) begin
                data_ff <= s_axi_wdata;
                strb_ff <= s_axi_wstrb;
            end
        end
    end


    // ***************************************************
    // Commit to the store
    // ***************************************************
    // Commit when the second beat of the pair lands
    wire commit = (state_ff != CIW_RESP) && (nxt_state == CIW_RESP);
    // Use live inputs for any beat arriving this cycle
    wire [`CIW_ADDR_W-1:0] cAddr = awHs ? s_axi_awaddr : addr_ff;
    assign regBus.wrEn   = commit;                         // see [R8]
    assign regBus.wrIdx  = cAddr[4:2];                     // see [R7]
    assign regBus.wrData = wHs ? s_axi_wdata : data_ff;
    assign regBus.wrStrb = wHs ? s_axi_wstrb : strb_ff;

    ciw_reg_store #(.NUM_REGS(`CIW_NUM_REGS)) uStore (
        .clock   (clock),
        .rst_n   (rst_n),
        .wrPort  (regBus),
        .regFlat (regFlat)
    );

    // ***************************************************
    // LED source and control word
    // ***************************************************
    // Clock-health inputs come from other domains
    logic [3:0] healthMeta_ff; // First stage
    logic [3:0] health_ff;     // Second stage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            healthMeta_ff <= '0;
            health_ff     <= '0;
        end else begin
            healthMeta_ff <= {refLocked, refValid, vcxoValid, clkGood};
            health_ff     <= healthMeta_ff;
        end
    end

    // Build-time source choice
    wire ledSrc = (INITIAL_LED_MODE == 0) ? health_ff[0] :
                  (INITIAL_LED_MODE == 1) ? &health_ff[1:0] :
                                            &health_ff[3:0]; // see [R6]

    // LED and control word registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ledOut   <= 1'b0;
            ctrlWord <= `CIW_REG_RST;
        end else begin
            ledOut   <= ledSrc; // see [R6]
            ctrlWord <= regFlat[`CIW_DATA_W-1:0];
        end
    end

    // ***************************************************
    // Assertions
    // ***************************************************
    // Beat record kept apart from the state machine, so the check is not circular
    logic sawAddr_ff; // Address beat taken since last response
    logic sawData_ff; // Data beat taken since last response
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sawAddr_ff <= 1'b0;
            sawData_ff <= 1'b0;
        end else begin
            sawAddr_ff <= bHs ? 1'b0 : (sawAddr_ff || awHs);
            sawData_ff <= bHs ? 1'b0 : (sawData_ff || wHs);
        end
    end

    a_bvalid_after_both: assert property (@(posedge clock) disable iff (!rst_n)
        s_axi_bvalid |-> sawAddr_ff && sawData_ff) // see [R9]
        else $error("bvalid raised without a full write");
    a_bvalid_holds: assert property (@(posedge clock) disable iff (!rst_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) // see [R9]
        else $error("bvalid dropped before bready");
    a_no_ready_in_resp: assert property (@(posedge clock) disable iff (!rst_n)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // see [R5]
        else $error("ready raised while response pending");
    a_addr_captured: assert property (@(posedge clock) disable iff (!rst_n)
        awHs |=> addr_ff == $past(s_axi_awaddr)) // see [R5]
        else $error("address not captured on handshake");
    a_store_write: assert property (@(posedge clock) disable iff (!rst_n)
        commit && regBus.wrIdx == 3'h0 && regBus.wrStrb == 4'hF
        |=> ##1 ctrlWord == $past(regBus.wrData, 2)) // see [R8]
        else $error("register 0 not written");
    a_okay_resp: assert property (@(posedge clock) disable iff (!rst_n)
        s_axi_bvalid |-> s_axi_bresp == 2'h0) // see [R9]
        else $error("response not OKAY");
    a_led_follows: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 ledOut == $past(ledSrc)) // see [R6]
        else $error("LED does not follow selected source");
    a_resp_clears: assert property (@(posedge clock) disable iff (!rst_n)
        bHs |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) // see [R5]
        else $error("channel did not return to idle");
endmodule
`default_nettype wire

// file: test/ciw_axi_master.sv
// Bus master model issuing single AXI4-Lite writes
`timescale 1ns/1ns
`default_nettype none
`include "ciw_defines.svh"
module ciw_axi_master (
    input  wire logic                   clock,
    output logic [`CIW_ADDR_W-1:0]      awAddr,
    output logic [`CIW_PROT_W-1:0]      awProt,
    output logic                        awValid,
    input  wire logic                   awReady,
    output logic [`CIW_DATA_W-1:0]      wData,
    output logic [`CIW_STRB_W-1:0]      wStrb,
    output logic                        wValid,
    input  wire logic                   wReady,
    input  wire logic [`CIW_RESP_W-1:0] bResp,
    input  wire logic                   bValid,
    output logic                        bReady,
    output logic                        stuck
);
    // ************************
    // Idle state at time zero
    // ************************
    initial begin
        {awAddr, awProt, awValid, wData, wStrb, wValid, bReady, stuck} = '0;
    end
    // Called just after an edge; each channel holds until its ready edge
    task automatic write(input logic [4:0] a, input logic [2:0] p, input logic [31:0] d,
                         input logic [3:0] s, input int aGap, input int wGap,
                         output logic [1:0] resp);
        int n;
        int m;
        fork
            begin
                repeat (aGap) @(posedge clock);
                if (aGap > 0) #1;
                awAddr = a;
                awProt = p;
                awValid = 1'b1;
                n = 0;
                @(posedge clock);
                while (!awReady && n < 50) begin
                    n++;
                    @(posedge clock);
                end
                if (n == 50) stuck = 1'b1;
                #1 awValid = 1'b0;
                awAddr = ~a; // Released lines show garbage, not the old address
            end
            begin
                repeat (wGap) @(posedge clock);
                if (wGap > 0) #1;
                wData = d;
                wStrb = s;
                wValid = 1'b1;
                m = 0;
                @(posedge clock);
                while (!wReady && m < 50) begin
                    m++;
                    @(posedge clock);
                end
                if (m == 50) stuck = 1'b1;
                #1 wValid = 1'b0;
                wData = ~d;
            end
        join
        bReady = 1'b1;
        n = 0;
        @(posedge clock);
        while (!bValid && n < 50) begin
            n++;
            @(posedge clock);
        end
        if (n == 50) stuck = 1'b1;
        resp = bResp;
        #1 bReady = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/tb_clock_iface_csr_write.sv
// Self-checking bench for the CSR write front end
`timescale 1ns/1ns
`default_nettype none
`include "ciw_defines.svh"
module tb_clock_iface_csr_write;
    import ciw_pkg::*;
    typedef struct { logic [4:0] a; logic [2:0] p; logic [31:0] d; logic [3:0] s;
                     int ag; int wg; logic [3:0] h; } ciw_row_t;
    logic clock, rst_n, awValid, awReady, wValid, wReady, bValid, bReady, stuck;
    logic [4:0]  awAddr;
    logic [2:0]  awProt, ledAll;
    logic [31:0] wData, ctrlWord, shadow;
    logic [3:0]  wStrb, health;
    logic [1:0]  bResp, resp;
    int mismatches = 0;
    int n_tests = 0;
    // Gaps exercise address-first, data-first and joint arrival
    ciw_row_t rows[6] = '{
        '{5'h00, 3'h0, 32'h12345678, 4'hF, 0, 0, 4'hF},
        '{5'h00, 3'h7, 32'hAABBCCDD, 4'h5, 0, 2, 4'h1},
        '{5'h04, 3'h2, 32'hFFFFFFFF, 4'hF, 2, 0, 4'h3},
        '{5'h1C, 3'h5, 32'h00000000, 4'hF, 0, 0, 4'h7},
        '{5'h01, 3'h3, 32'h11223344, 4'hA, 1, 1, 4'hE},
        '{5'h00, 3'h0, 32'h00000000, 4'h0, 0, 0, 4'h0}};
    // ************************
    // Clock, parts
    // ************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    ciw_axi_master u_mst (.clock(clock), .awAddr(awAddr), .awProt(awProt),
        .awValid(awValid), .awReady(awReady), .wData(wData), .wStrb(wStrb),
        .wValid(wValid), .wReady(wReady), .bResp(bResp), .bValid(bValid),
        .bReady(bReady), .stuck(stuck));
    ciw_csr_write #(.INITIAL_LED_MODE(2)) u_dut (.clock(clock), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awprot(awProt), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .clkGood(health[0]),
        .vcxoValid(health[1]), .refValid(health[2]), .refLocked(health[3]),
        .ledOut(ledAll[2]), .ctrlWord(ctrlWord));
    // Modes 0 and 1 see the same traffic; only their LED is watched
    for (genvar g = 0; g < 2; g++) begin : g_led
        ciw_csr_write #(.INITIAL_LED_MODE(g)) u_led (.clock(clock), .rst_n(rst_n),
            .s_axi_awaddr(awAddr), .s_axi_awprot(awProt), .s_axi_awvalid(awValid),
            .s_axi_awready(), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
            .s_axi_wvalid(wValid), .s_axi_wready(), .s_axi_bresp(),
            .s_axi_bvalid(), .s_axi_bready(bReady), .clkGood(health[0]),
            .vcxoValid(health[1]), .refValid(health[2]), .refLocked(health[3]),
            .ledOut(ledAll[g]), .ctrlWord());
    end
    // Compare with case equality so unknowns fail
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    // ************************
    // Main sequence
    // ************************
    initial begin
        rst_n = 1'b0;
        health = 4'h0;
        shadow = 32'h0;
        repeat (6) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        for (int i = 0; i < 6; i++) begin
            health = rows[i].h;
            u_mst.write(rows[i].a, rows[i].p, rows[i].d, rows[i].s, rows[i].ag, rows[i].wg, resp);
            for (int b = 0; b < 4; b++) begin
                if (rows[i].a[4:2] == 3'h0 && rows[i].s[b]) begin
                    shadow[8*b +: 8] = rows[i].d[8*b +: 8];
                end
            end
            repeat (2) @(posedge clock);
            #1;
            check(ctrlWord, shadow);
            check(resp, 32'h0);
            check(stuck, 32'h0);
            check(ledAll, {&health, &health[1:0], health[0]});
        end
        // Reset in mid-run clears the word and the handshake outputs
        rst_n = 1'b0;
        #1;
        // Split in two: the flags and the word together exceed one compare
        check({awReady, wReady, bValid, ledAll}, 32'h0);
        check(ctrlWord, 32'h0);
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        u_mst.write(5'h00, 3'h1, 32'hC0FFEE01, 4'h1, 0, 0, resp);
        repeat (2) @(posedge clock);
        #1;
        check(ctrlWord, 32'h00000001);
        check(stuck, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
